// >>> rtl/bid_pkg.sv
// Purpose: shared constants and state types for the branch/increment decode block
// Assumes: 200 MHz clock MCLK_I, asynchronous active-high reset RST_I
// Notes: register map is word aligned on a 32-bit AXI4-Lite slave
package bid_pkg;

   // ==========================================================
   // widths
   localparam int ADDR_W = 8;
   localparam int AXI_DATA_W = 32;
   localparam int STRB_W = 4;
   localparam int PC_W = 11;
   localparam int INSTR_W = 12;
   localparam int DATA_W = 8;
   localparam int FILE_N = 32;
   localparam int FILE_AW = 5;

   // ==========================================================
   // register map (byte addresses)
   localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_WREG = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_PC = 8'h0C;
   localparam logic [ADDR_W-1:0] OFF_IR = 8'h10;
   localparam int FILE_SEL_BIT = 7;
   localparam int WORD_LSB = 2;

   // ==========================================================
   // field positions
   localparam int CTRL_RUN = 0;
   localparam int STAT_Z = 2;
   localparam int STAT_PAGE_LO = 5;
   localparam int STAT_PAGE_HI = 6;
   localparam int PC_PAGE_LO = 9;
   localparam int PC_PAGE_HI = 10;
   localparam int K_MSB = 8;
   localparam int D_BIT = 5;
   localparam int F_MSB = 4;
   localparam int BYTE_W = 8;

   // ==========================================================
   // instruction encodings
   localparam logic [2:0] OP_JUMP = 3'h5;
   localparam logic [5:0] OP_INC = 6'h0A;
   localparam logic [5:0] OP_INC_SKIP = 6'h0F;
   localparam logic [INSTR_W-1:0] INSTR_NOP = 12'h000;
   localparam logic [PC_W-1:0] PC_STEP = 11'h001;
   localparam logic [DATA_W-1:0] INC_STEP = 8'h01;
   localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;

   // ==========================================================
   // reset values
   localparam logic [PC_W-1:0] RST_PC = 11'h000;
   localparam logic [DATA_W-1:0] RST_W = 8'h00;
   localparam logic [DATA_W-1:0] RST_STATUS = 8'h00;
   localparam logic [DATA_W-1:0] RST_FILE = 8'h00;

   // ==========================================================
   // bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic run;
      logic [PC_W-1:0] pc;
      logic [INSTR_W-1:0] ir;
      logic [DATA_W-1:0] w;
      logic [DATA_W-1:0] status;
      logic [FILE_N-1:0][DATA_W-1:0] rf;
   } bid_core_s;

   localparam bid_core_s CORE_RST = '{run: 1'b0, pc: RST_PC, ir: INSTR_NOP, w: RST_W,
                                      status: RST_STATUS, rf: {FILE_N{RST_FILE}}};

   typedef struct packed {
      logic aw_got;
      logic w_got;
      logic [ADDR_W-1:0] awaddr;
      logic [AXI_DATA_W-1:0] wdata;
      logic [STRB_W-1:0] wstrb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [AXI_DATA_W-1:0] rdata;
      logic [1:0] rresp;
   } bid_axs_s;

   localparam bid_axs_s AXS_RST = '{aw_got: 1'b0, w_got: 1'b0, awaddr: '0, wdata: '0, wstrb: '0,
                                    awready: 1'b1, wready: 1'b1, bvalid: 1'b0, bresp: RESP_OKAY,
                                    arready: 1'b1, rvalid: 1'b0, rdata: '0, rresp: RESP_OKAY};

endpackage : bid_pkg

// >>> rtl/bid_reg_if.sv
// Purpose: register access strobes between the bus slave and the core
// Assumes: single clock domain
// Notes: read data is combinational from the core state
interface bid_reg_if;
   logic wr_en;
   logic [bid_pkg::ADDR_W-1:0] wr_addr;
   logic [bid_pkg::AXI_DATA_W-1:0] wr_data;
   logic [bid_pkg::STRB_W-1:0] wr_strb;
   logic wr_ok;
   logic [bid_pkg::ADDR_W-1:0] rd_addr;
   logic [bid_pkg::AXI_DATA_W-1:0] rd_data;
   logic rd_ok;

   modport bus (output wr_en, output wr_addr, output wr_data, output wr_strb, input wr_ok,
                output rd_addr, input rd_data, input rd_ok);
   modport regs (input wr_en, input wr_addr, input wr_data, input wr_strb, output wr_ok,
                 input rd_addr, output rd_data, output rd_ok);
endinterface : bid_reg_if

// >>> rtl/bid_axil_slave.sv
// Purpose: AXI4-Lite slave front end for the decode block registers
// Assumes: one outstanding write and one outstanding read
// Notes: all bus outputs come from flip-flops
module bid_axil_slave
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // write channels
   input wire logic [bid_pkg::ADDR_W-1:0] awaddr_i,
   input wire logic awvalid_i,
   output logic awready_o,
   input wire logic [bid_pkg::AXI_DATA_W-1:0] wdata_i,
   input wire logic [bid_pkg::STRB_W-1:0] wstrb_i,
   input wire logic wvalid_i,
   output logic wready_o,
   output logic [1:0] bresp_o,
   output logic bvalid_o,
   input wire logic bready_i,
   // read channels
   input wire logic [bid_pkg::ADDR_W-1:0] araddr_i,
   input wire logic arvalid_i,
   output logic arready_o,
   output logic [bid_pkg::AXI_DATA_W-1:0] rdata_o,
   output logic [1:0] rresp_o,
   output logic rvalid_o,
   input wire logic rready_i,
   // register side
   bid_reg_if.bus regs
);

   bid_pkg::bid_axs_s s_r;
   bid_pkg::bid_axs_s s_nxt;

   // ==========================================================
   // channel handling
   always_comb
   begin
      s_nxt = s_r;
      regs.wr_en = 1'b0;
      if (awvalid_i && s_r.awready)
      begin
         s_nxt.aw_got = 1'b1;
         s_nxt.awaddr = awaddr_i;
      end
      if (wvalid_i && s_r.wready)
      begin
         s_nxt.w_got = 1'b1;
         s_nxt.wdata = wdata_i;
         s_nxt.wstrb = wstrb_i;
      end
      // commit only once both halves are held, so aw and w may arrive in either order
      if (s_r.aw_got && s_r.w_got && !s_r.bvalid)
      begin
         regs.wr_en = 1'b1;
         s_nxt.bvalid = 1'b1;
         s_nxt.bresp = regs.wr_ok ? bid_pkg::RESP_OKAY : bid_pkg::RESP_SLVERR;
         s_nxt.aw_got = 1'b0;
         s_nxt.w_got = 1'b0;
      end
      if (s_r.bvalid && bready_i)
      begin
         s_nxt.bvalid = 1'b0;
      end
      s_nxt.awready = !s_nxt.aw_got && !s_nxt.bvalid;
      s_nxt.wready = !s_nxt.w_got && !s_nxt.bvalid;
      if (arvalid_i && s_r.arready)
      begin
         s_nxt.rvalid = 1'b1;
         s_nxt.rdata = regs.rd_data;
         s_nxt.rresp = regs.rd_ok ? bid_pkg::RESP_OKAY : bid_pkg::RESP_SLVERR;
         s_nxt.arready = 1'b0;
      end
      else if (s_r.rvalid && rready_i)
      begin
         s_nxt.rvalid = 1'b0;
         s_nxt.arready = 1'b1;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         s_r <= bid_pkg::AXS_RST;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   assign regs.wr_addr = s_r.awaddr;
   assign regs.wr_data = s_r.wdata;
   assign regs.wr_strb = s_r.wstrb;
   assign regs.rd_addr = araddr_i;
   assign awready_o = s_r.awready;
   assign wready_o = s_r.wready;
   assign bvalid_o = s_r.bvalid;
   assign bresp_o = s_r.bresp;
   assign arready_o = s_r.arready;
   assign rvalid_o = s_r.rvalid;
   assign rdata_o = s_r.rdata;
   assign rresp_o = s_r.rresp;

endmodule : bid_axil_slave

// >>> rtl/bid_core.sv
// Purpose: fetch/execute of the jump, increment and increment-skip-if-zero instructions
// Assumes: program memory answers PROG_ADDR_O with INSTR_I in the same cycle
// Notes: all other opcodes execute as no_operation
//
// Contract
// - jump_unconditional loads its 9-bit literal into program_counter bits 8..0.
// - jump copies status bits 6:5 into program_counter 10:9; takes two cycles.
// - increment_register adds one to the addressed file register in one cycle.
// - both increments write W when d is 0, the file register when d is 1.
// - increment_skip_zero increments, stores per d, and tests the result for zero.
// - a zero result discards the fetched instruction; no_operation runs instead.
module bid_core
(
   // clock and reset
   input wire logic MCLK_I,
   input wire logic RST_I,
   // AXI4-Lite write channels
   input wire logic [bid_pkg::ADDR_W-1:0] S_AXI_AWADDR_I,
   input wire logic S_AXI_AWVALID_I,
   output logic S_AXI_AWREADY_O,
   input wire logic [bid_pkg::AXI_DATA_W-1:0] S_AXI_WDATA_I,
   input wire logic [bid_pkg::STRB_W-1:0] S_AXI_WSTRB_I,
   input wire logic S_AXI_WVALID_I,
   output logic S_AXI_WREADY_O,
   output logic [1:0] S_AXI_BRESP_O,
   output logic S_AXI_BVALID_O,
   input wire logic S_AXI_BREADY_I,
   // AXI4-Lite read channels
   input wire logic [bid_pkg::ADDR_W-1:0] S_AXI_ARADDR_I,
   input wire logic S_AXI_ARVALID_I,
   output logic S_AXI_ARREADY_O,
   output logic [bid_pkg::AXI_DATA_W-1:0] S_AXI_RDATA_O,
   output logic [1:0] S_AXI_RRESP_O,
   output logic S_AXI_RVALID_O,
   input wire logic S_AXI_RREADY_I,
   // program memory fetch path
   output logic [bid_pkg::PC_W-1:0] PROG_ADDR_O,
   output logic FETCH_EN_O,
   input wire logic [bid_pkg::INSTR_W-1:0] INSTR_I,
   // core state
   output logic [bid_pkg::DATA_W-1:0] W_O,
   output logic [bid_pkg::DATA_W-1:0] STATUS_O
);

   bid_reg_if regs ();

   bid_pkg::bid_core_s s_r;
   bid_pkg::bid_core_s s_nxt;

   logic [bid_pkg::FILE_AW-1:0] exe_f;
   logic exe_d;
   logic [bid_pkg::DATA_W-1:0] inc_res;
   logic inc_zero;
   logic is_jump;
   logic is_inc;
   logic is_inc_skip;
   logic wr_file;
   logic rd_file;
   logic [bid_pkg::FILE_AW-1:0] wr_idx;
   logic [bid_pkg::FILE_AW-1:0] rd_idx;
   logic [bid_pkg::ADDR_W-1:0] wr_word;
   logic [bid_pkg::ADDR_W-1:0] rd_word;

   // ==========================================================
   // bus slave
   bid_axil_slave u_axil
   (
      .clk_i (MCLK_I),
      .rst_i (RST_I),
      .awaddr_i (S_AXI_AWADDR_I),
      .awvalid_i (S_AXI_AWVALID_I),
      .awready_o (S_AXI_AWREADY_O),
      .wdata_i (S_AXI_WDATA_I),
      .wstrb_i (S_AXI_WSTRB_I),
      .wvalid_i (S_AXI_WVALID_I),
      .wready_o (S_AXI_WREADY_O),
      .bresp_o (S_AXI_BRESP_O),
      .bvalid_o (S_AXI_BVALID_O),
      .bready_i (S_AXI_BREADY_I),
      .araddr_i (S_AXI_ARADDR_I),
      .arvalid_i (S_AXI_ARVALID_I),
      .arready_o (S_AXI_ARREADY_O),
      .rdata_o (S_AXI_RDATA_O),
      .rresp_o (S_AXI_RRESP_O),
      .rvalid_o (S_AXI_RVALID_O),
      .rready_i (S_AXI_RREADY_I),
      .regs (regs.bus)
   );

   // ==========================================================
   // decode of the instruction in execute
   assign exe_f = s_r.ir[bid_pkg::F_MSB:0];
   assign exe_d = s_r.ir[bid_pkg::D_BIT];
   assign is_jump = s_r.run && (s_r.ir[bid_pkg::INSTR_W-1:bid_pkg::K_MSB+1] == bid_pkg::OP_JUMP);
   assign is_inc = s_r.run && (s_r.ir[bid_pkg::INSTR_W-1:bid_pkg::D_BIT+1] == bid_pkg::OP_INC);
   assign is_inc_skip = s_r.run && (s_r.ir[bid_pkg::INSTR_W-1:bid_pkg::D_BIT+1] == bid_pkg::OP_INC_SKIP);
   assign inc_res = s_r.rf[exe_f] + bid_pkg::INC_STEP;
   assign inc_zero = (inc_res == bid_pkg::DATA_ZERO);

   // ==========================================================
   // register decode
   assign wr_word = {regs.wr_addr[bid_pkg::ADDR_W-1:bid_pkg::WORD_LSB], 2'b00};
   assign rd_word = {regs.rd_addr[bid_pkg::ADDR_W-1:bid_pkg::WORD_LSB], 2'b00};
   assign wr_file = regs.wr_addr[bid_pkg::FILE_SEL_BIT];
   assign rd_file = regs.rd_addr[bid_pkg::FILE_SEL_BIT];
   assign wr_idx = regs.wr_addr[bid_pkg::WORD_LSB+bid_pkg::FILE_AW-1:bid_pkg::WORD_LSB];
   assign rd_idx = regs.rd_addr[bid_pkg::WORD_LSB+bid_pkg::FILE_AW-1:bid_pkg::WORD_LSB];
   assign regs.wr_ok = wr_file || (wr_word == bid_pkg::OFF_CTRL) || (wr_word == bid_pkg::OFF_STATUS)
                       || (wr_word == bid_pkg::OFF_WREG) || (wr_word == bid_pkg::OFF_PC);

   always_comb
   begin
      regs.rd_data = '0;
      regs.rd_ok = 1'b1;
      if (rd_file)
      begin
         regs.rd_data[bid_pkg::DATA_W-1:0] = s_r.rf[rd_idx];
      end
      else
      begin
         case (rd_word)
            bid_pkg::OFF_CTRL: regs.rd_data[bid_pkg::CTRL_RUN] = s_r.run;
            bid_pkg::OFF_STATUS: regs.rd_data[bid_pkg::DATA_W-1:0] = s_r.status;
            bid_pkg::OFF_WREG: regs.rd_data[bid_pkg::DATA_W-1:0] = s_r.w;
            bid_pkg::OFF_PC: regs.rd_data[bid_pkg::PC_W-1:0] = s_r.pc;
            bid_pkg::OFF_IR: regs.rd_data[bid_pkg::INSTR_W-1:0] = s_r.ir;
            default: regs.rd_ok = 1'b0;
         endcase
      end
   end

   // ==========================================================
   // next state: software write first, then execution, so the core wins a same-cycle clash
   always_comb
   begin
      s_nxt = s_r;
      if (regs.wr_en && regs.wr_ok)
      begin
         if (wr_file)
         begin
            if (regs.wr_strb[0])
            begin
               s_nxt.rf[wr_idx] = regs.wr_data[bid_pkg::DATA_W-1:0];
            end
         end
         else if (regs.wr_strb[0])
         begin
            case (wr_word)
               bid_pkg::OFF_CTRL: s_nxt.run = regs.wr_data[bid_pkg::CTRL_RUN];
               bid_pkg::OFF_STATUS: s_nxt.status = regs.wr_data[bid_pkg::DATA_W-1:0];
               bid_pkg::OFF_WREG: s_nxt.w = regs.wr_data[bid_pkg::DATA_W-1:0];
               bid_pkg::OFF_PC: s_nxt.pc[bid_pkg::BYTE_W-1:0] = regs.wr_data[bid_pkg::BYTE_W-1:0];
               default: s_nxt.run = s_r.run;
            endcase
         end
         if (!wr_file && (wr_word == bid_pkg::OFF_PC) && regs.wr_strb[1])
         begin
            s_nxt.pc[bid_pkg::PC_W-1:bid_pkg::BYTE_W] = regs.wr_data[bid_pkg::PC_W-1:bid_pkg::BYTE_W];
         end
      end
      if (s_r.run)
      begin
         // fetch: the word on INSTR_I belongs to the current program counter
         s_nxt.ir = INSTR_I;
         s_nxt.pc = s_r.pc + bid_pkg::PC_STEP;
         if (is_jump)
         begin
            s_nxt.pc[bid_pkg::K_MSB:0] = s_r.ir[bid_pkg::K_MSB:0];
            s_nxt.pc[bid_pkg::PC_PAGE_HI:bid_pkg::PC_PAGE_LO] =
               s_r.status[bid_pkg::STAT_PAGE_HI:bid_pkg::STAT_PAGE_LO];
            // the word fetched behind a jump is stale, so a bubble makes it two cycles
            s_nxt.ir = bid_pkg::INSTR_NOP;
         end
         if (is_inc || is_inc_skip)
         begin
            if (exe_d)
            begin
               s_nxt.rf[exe_f] = inc_res;
            end
            else
            begin
               s_nxt.w = inc_res;
            end
         end
         if (is_inc)
         begin
            s_nxt.status[bid_pkg::STAT_Z] = inc_zero;
         end
         if (is_inc_skip && inc_zero)
         begin
            s_nxt.ir = bid_pkg::INSTR_NOP;
         end
      end
   end

   always_ff @(posedge MCLK_I or posedge RST_I)
   begin
      if (RST_I)
      begin
         s_r <= bid_pkg::CORE_RST;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   assign PROG_ADDR_O = s_r.pc;
   assign FETCH_EN_O = s_r.run;
   assign W_O = s_r.w;
   assign STATUS_O = s_r.status;

endmodule : bid_core

// >>> tb/bid_asserts.sv
// Purpose: port timing checks of the decode block
// Assumes: program memory answers in the fetch cycle
// Notes: a word fetched behind a branch starts no check
module bid_asserts
(
   // clock and reset
   input wire logic MCLK_I,
   input wire logic RST_I,
   // bus handshakes
   input wire logic S_AXI_AWVALID_I,
   input wire logic S_AXI_AWREADY_O,
   input wire logic S_AXI_WVALID_I,
   input wire logic S_AXI_WREADY_O,
   input wire logic S_AXI_BVALID_O,
   input wire logic S_AXI_ARVALID_I,
   input wire logic S_AXI_ARREADY_O,
   input wire logic S_AXI_RVALID_O,
   // core
   input wire logic [10:0] PROG_ADDR_O,
   input wire logic FETCH_EN_O,
   input wire logic [11:0] INSTR_I,
   input wire logic [7:0] W_O,
   input wire logic [7:0] STATUS_O
);
   timeunit 1ns;
   timeprecision 1ps;
   // =====
   // fetch tracking
   logic br_r;
   logic jmp, inc, skp;
   logic [1:0] pg;
   logic [8:0] lit;
   assign pg = STATUS_O[6:5];
   assign lit = INSTR_I[8:0];
   assign jmp = FETCH_EN_O && INSTR_I[11:9] == 3'h5 && !br_r;
   assign inc = FETCH_EN_O && INSTR_I[11:6] == 6'h0A && !br_r;
   assign skp = FETCH_EN_O && INSTR_I[11:6] == 6'h0F && !br_r;
   // the word behind a branch may be squashed, so it is not trusted
   always_ff @(posedge MCLK_I or posedge RST_I)
      if (RST_I)
         br_r <= 1'b0;
      else if (FETCH_EN_O)
         br_r <= INSTR_I[11:9] == 3'h5 || INSTR_I[11:6] == 6'h0F;
   default clocking cb @(posedge MCLK_I);
   endclocking
   default disable iff (RST_I);
   // =====
   // properties
   property p_jump_target;
      jmp ##1 FETCH_EN_O |=> PROG_ADDR_O == {$past(pg), $past(lit, 2)};
   endproperty
   a_jump_target: assert property (p_jump_target) else $error("jump target");
   property p_jump_quiet;
      jmp ##1 FETCH_EN_O ##1 FETCH_EN_O |=> STATUS_O == $past(STATUS_O, 2) && W_O == $past(W_O, 2);
   endproperty
   a_jump_quiet: assert property (p_jump_quiet) else $error("jump side effect");
   property p_inc_zero;
      inc && !INSTR_I[5] ##1 FETCH_EN_O |=> STATUS_O[2] == (W_O == 8'h00)
         && ((STATUS_O ^ $past(STATUS_O)) & 8'hFB) == 8'h00;
   endproperty
   a_inc_zero: assert property (p_inc_zero) else $error("inc zero flag");
   property p_inc_file;
      (inc || skp) && INSTR_I[5] ##1 FETCH_EN_O |=> $stable(W_O);
   endproperty
   a_inc_file: assert property (p_inc_file) else $error("w written");
   property p_skip_flags;
      skp ##1 FETCH_EN_O |=> $stable(STATUS_O);
   endproperty
   a_skip_flags: assert property (p_skip_flags) else $error("skip flags");
   property p_skip_squash;
      skp && !INSTR_I[5] ##1 FETCH_EN_O ##1 FETCH_EN_O && W_O == 8'h00 |=> $stable(W_O);
   endproperty
   a_skip_squash: assert property (p_skip_squash) else $error("skip not squashed");
   property p_wr_answer;
      S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O
         |=> !S_AXI_AWREADY_O ##1 S_AXI_BVALID_O;
   endproperty
   a_wr_answer: assert property (p_wr_answer) else $error("write answer");
   property p_rd_answer;
      S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O && !S_AXI_ARREADY_O;
   endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("read answer");
endmodule : bid_asserts

bind bid_core bid_asserts i_bid_asserts
(
   .MCLK_I(MCLK_I),
   .RST_I(RST_I),
   .S_AXI_AWVALID_I(S_AXI_AWVALID_I),
   .S_AXI_AWREADY_O(S_AXI_AWREADY_O),
   .S_AXI_WVALID_I(S_AXI_WVALID_I),
   .S_AXI_WREADY_O(S_AXI_WREADY_O),
   .S_AXI_BVALID_O(S_AXI_BVALID_O),
   .S_AXI_ARVALID_I(S_AXI_ARVALID_I),
   .S_AXI_ARREADY_O(S_AXI_ARREADY_O),
   .S_AXI_RVALID_O(S_AXI_RVALID_O),
   .PROG_ADDR_O(PROG_ADDR_O),
   .FETCH_EN_O(FETCH_EN_O),
   .INSTR_I(INSTR_I),
   .W_O(W_O),
   .STATUS_O(STATUS_O)
);

// >>> tb/bid_prog_mem.sv
// Purpose: program memory on the fetch path
// Assumes: word answered in the cycle its address shows
// Notes: output inverted while fetch is off, so stale words are never trusted
module bid_prog_mem
(
   // fetch port
   input wire logic [10:0] addr_i,
   input wire logic fetch_en_i,
   output logic [11:0] instr_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [11:0] mem [0:2047];
   initial
   begin
      foreach (mem[i])
         mem[i] = 12'h000;
   end
   assign instr_o = fetch_en_i ? mem[addr_i] : ~mem[addr_i];
endmodule : bid_prog_mem

// >>> tb/tb.sv
// Purpose: register-bus driven checks of the decode block
// Assumes: program loaded before the core is started
// Notes: the program ends in a jump loop and is then stopped
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   // =====
   // signals
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, fe;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [10:0] pa;
   logic [11:0] ins;
   logic [7:0] w, st;
   int error_cnt = 0;
   int tests_run = 0;
   int n;
   localparam logic [5:0] op_inc = 6'h0A;
   localparam logic [5:0] op_skp = 6'h0F;
   localparam logic [2:0] op_jmp = 3'h5;
   logic [7:0] ra [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h80, 8'hFC};
   always #2.5 clk = ~clk;
   bid_core i_bid_core
   (
      .MCLK_I(clk),
      .RST_I(rst),
      .S_AXI_AWADDR_I(awaddr),
      .S_AXI_AWVALID_I(awvalid),
      .S_AXI_AWREADY_O(awready),
      .S_AXI_WDATA_I(wdata),
      .S_AXI_WSTRB_I(wstrb),
      .S_AXI_WVALID_I(wvalid),
      .S_AXI_WREADY_O(wready),
      .S_AXI_BRESP_O(bresp),
      .S_AXI_BVALID_O(bvalid),
      .S_AXI_BREADY_I(bready),
      .S_AXI_ARADDR_I(araddr),
      .S_AXI_ARVALID_I(arvalid),
      .S_AXI_ARREADY_O(arready),
      .S_AXI_RDATA_O(rdata),
      .S_AXI_RRESP_O(rresp),
      .S_AXI_RVALID_O(rvalid),
      .S_AXI_RREADY_I(rready),
      .PROG_ADDR_O(pa),
      .FETCH_EN_O(fe),
      .INSTR_I(ins),
      .W_O(w),
      .STATUS_O(st)
   );
   bid_prog_mem i_bid_prog_mem
   (
      .addr_i(pa),
      .fetch_en_i(fe),
      .instr_o(ins)
   );
   // =====
   // tasks
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e)
      begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic results;
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : results
   task automatic hang;
      error_cnt++;
      results();
   endtask : hang
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] e);
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 1; n <= 50; n++)
      begin
         @(posedge clk);
         if (awready)
            awvalid <= 1'b0;
         if (wready)
            wvalid <= 1'b0;
         if (bvalid === 1'b1)
            break;
      end
      bready <= 1'b0;
      if (n > 50)
         hang();
      chk("bresp", {30'h0, e}, {30'h0, bresp});
   endtask : wr
   task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 1; n <= 50; n++)
      begin
         @(posedge clk);
         if (arready)
            arvalid <= 1'b0;
         if (rvalid === 1'b1)
            break;
      end
      rready <= 1'b0;
      if (n > 50)
         hang();
      chk(nm, e, rdata);
      chk("rresp", {30'h0, er}, {30'h0, rresp});
   endtask : rd_chk
   task automatic ld(input logic [10:0] a, input logic [11:0] d);
      i_bid_prog_mem.mem[a] = d;
   endtask : ld
   // =====
   // sequence
   initial
   begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk("pins", 32'h0, {4'h0, pa, fe, w, st});
      foreach (ra[i])
         rd_chk("reset", ra[i], 32'h0, 2'h0);
      rd_chk("hole", 8'h14, 32'h0, 2'h2);
      wr(8'h14, 32'hFF, 4'hF, 2'h2);
      wr(8'h10, 32'h1, 4'hF, 2'h2);
      ld(11'h000, {op_inc, 1'b1, 5'h01});
      ld(11'h001, {op_inc, 1'b0, 5'h00});
      ld(11'h002, {op_skp, 1'b1, 5'h1F});
      ld(11'h003, {op_inc, 1'b1, 5'h01});
      ld(11'h004, {op_skp, 1'b1, 5'h02});
      ld(11'h005, {op_inc, 1'b1, 5'h01});
      ld(11'h006, {op_skp, 1'b0, 5'h00});
      ld(11'h007, {op_inc, 1'b0, 5'h01});
      ld(11'h008, {op_jmp, 9'h1FF});
      ld(11'h009, {op_inc, 1'b0, 5'h01});
      ld(11'h5FF, {op_inc, 1'b1, 5'h1F});
      ld(11'h600, {op_jmp, 9'h000});
      ld(11'h601, {op_inc, 1'b0, 5'h01});
      ld(11'h400, {op_jmp, 9'h000});
      ld(11'h401, {op_inc, 1'b0, 5'h01});
      wr(8'h80, 32'hFF, 4'hF, 2'h0);
      wr(8'h84, 32'h10, 4'hF, 2'h0);
      wr(8'h88, 32'hFF, 4'hF, 2'h0);
      wr(8'hFC, 32'h05, 4'hF, 2'h0);
      wr(8'h08, 32'h5A, 4'hF, 2'h0);
      wr(8'h08, 32'hFF00, 4'h2, 2'h0);
      rd_chk("lane", 8'h08, 32'h5A, 2'h0);
      wr(8'h04, 32'h44, 4'hF, 2'h0);
      wr(8'h00, 32'h1, 4'hF, 2'h0);
      for (n = 1; n <= 200; n++)
      begin
         @(posedge clk);
         if (pa[10:1] === 10'h200)
            break;
      end
      if (n > 200)
         hang();
      repeat (6) @(posedge clk);
      wr(8'h00, 32'h0, 4'hF, 2'h0);
      rd_chk("w", 8'h08, 32'h00, 2'h0);
      rd_chk("f0", 8'h80, 32'hFF, 2'h0);
      rd_chk("f1", 8'h84, 32'h12, 2'h0);
      rd_chk("f2", 8'h88, 32'h00, 2'h0);
      rd_chk("f31", 8'hFC, 32'h07, 2'h0);
      rd_chk("status", 8'h04, 32'h40, 2'h0);
      chk("pc", 32'h200, {22'h0, pa[10:1]});
      chk("w pin", 32'h00, {24'h0, w});
      results();
   end
endmodule : tb
